// ===== rtl/host_support_pkg.sv
// package for the host controller support block: register map, field
// positions, reset values, timing counts and the bus request carrier.
// assumes a single 250 MHz clock that also serves as the system bus clock.
package host_support_pkg;

    // register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] FAULT_ADDR_OFS = 8'h00;
    localparam logic [7:0] FAULT_DIR_OFS = 8'h04;
    localparam logic [7:0] TIMEOUT_CTRL_OFS = 8'h08;
    localparam logic [7:0] REVISION_OFS = 8'h0C;
    localparam logic [7:0] ERROR_FLAG_OFS = 8'h10;

    // field positions
    localparam int FAULT_DIR_BIT = 0;
    localparam int TIMEOUT_DIS_BIT = 0;
    localparam int ERROR_FLAG_BIT = 0;
    localparam int MAJOR_LSB = 4;
    localparam int MINOR_LSB = 0;

    // reset values
    localparam logic [31:0] FAULT_ADDR_RST = 32'h0000_0000;
    localparam logic FAULT_DIR_RST = 1'b0;
    localparam logic TIMEOUT_DIS_RST = 1'b0;

    // revision numbers, values arbitrary
    localparam logic [3:0] MAJOR_REV = 4'h1;
    localparam logic [3:0] MINOR_REV = 4'h2;

    // clock rate and timing
    localparam int CLK_MHZ = 250;
    localparam int TIMEOUT_CYCLES = 4096;
    localparam logic [12:0] TIMEOUT_LAST = 13'(TIMEOUT_CYCLES - 1);
    localparam int RESET_SLOW_CYCLES = 72;
    localparam int SLOW_CLK_MHZ = 48;
    // internal reset time in ns, then the wait in fast cycles, rounded up
    localparam int RESET_TIME_NS = (RESET_SLOW_CYCLES * 1000) / SLOW_CLK_MHZ;
    localparam int RESET_WAIT_CYCLES = (RESET_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam logic [9:0] RESET_WAIT_LAST = 10'(RESET_WAIT_CYCLES - 1);

    // synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 3;

    // standard interrupt sources from the controller core
    localparam int STD_IRQ_W = 6;

    // controller gating inputs, bit positions inside the synchronised group
    localparam int CFG_PAD_SEL = 0;
    localparam int CFG_HOST_EN = 1;
    localparam int CFG_MOD_EN = 2;
    localparam int CFG_PER_REL = 3;
    localparam int CFG_SOFT_RST = 4;
    localparam int CFG_W = 5;

    // one system bus access: physical address and direction
    typedef struct packed {
        logic [31:0] addr;
        logic write;
    } bus_req_t;

    // bus master state
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } master_state_t;

endpackage : host_support_pkg

// ===== rtl/pin_sync.sv
// three-stage synchroniser for a group of slow pin level inputs.
// assumes inputs are levels that hold for several clocks.
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    import host_support_pkg::*;

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] out_r;
    logic [W-1:0] out_nxt;

    // a change counts once the second and third stages agree
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_comb begin
                out_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : out_r[g];
            end
        end
    endgenerate

    // stage registers, first stage read only by the second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            out_r <= '0;
        end else if (ce) begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            out_r <= out_nxt;
        end
    end

    assign level_out = out_r;

endmodule : pin_sync

// ===== rtl/host_support.sv
// host controller support logic: system bus time-out, fault capture,
// revision register, controller clock and reset gating, interrupt line.
// assumes core and system bus share clk; gating bits arrive as async pins.
`timescale 1ns/1ps
module host_support (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // register port
    input wire logic [host_support_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [host_support_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [host_support_pkg::DATA_W-1:0] reg_rdata,
    // gating pins
    input wire logic pad_enable_select,
    input wire logic host_enable_bit,
    input wire logic module_config_host_enable,
    input wire logic peripheral_release_bit,
    input wire logic soft_reset_bit,
    output logic ctl_clk_en,
    output logic ctl_rst_n,
    output logic ctl_ready,
    // access request from the controller core
    input wire logic core_req_valid,
    input wire host_support_pkg::bus_req_t core_req,
    output logic core_req_taken,
    output logic core_done,
    output logic core_fault,
    // system memory bus master side
    output logic bus_valid,
    output host_support_pkg::bus_req_t bus_req,
    input wire logic bus_done,
    // interrupt sources from the core
    input wire logic [host_support_pkg::STD_IRQ_W-1:0] std_irq,
    input wire logic iso_fault,
    output logic irq
);
    import host_support_pkg::*;

    // synchronised gating levels
    logic [CFG_W-1:0] cfg_pins;
    logic [CFG_W-1:0] cfg;

    assign cfg_pins = {soft_reset_bit, peripheral_release_bit, module_config_host_enable,
                       host_enable_bit, pad_enable_select};

    pin_sync #(
        .W(CFG_W)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .pin_in(cfg_pins),
        .level_out(cfg)
    );

    // register read decode, used by the read path only
    function automatic logic [DATA_W-1:0] read_mux(
        input logic [ADDR_W-1:0] a,
        input logic [31:0] faddr,
        input logic fdir,
        input logic todis,
        input logic ueflag
    );
        logic [DATA_W-1:0] d;
        d = '0;
        unique case (a)
            FAULT_ADDR_OFS: d = faddr;
            FAULT_DIR_OFS: d[FAULT_DIR_BIT] = fdir;
            TIMEOUT_CTRL_OFS: d[TIMEOUT_DIS_BIT] = todis;
            REVISION_OFS: d[7:0] = {MAJOR_REV, MINOR_REV};
            ERROR_FLAG_OFS: d[ERROR_FLAG_BIT] = ueflag;
            default: d = '0;
        endcase
        return d;
    endfunction : read_mux

    // controller clock and reset gating
    logic clk_en_r;
    logic clk_en_nxt;
    logic rst_n_r;
    logic rst_n_nxt;
    logic ready_r;
    logic ready_nxt;
    logic [9:0] rst_cnt_r;
    logic [9:0] rst_cnt_nxt;
    logic run;

    // gate selection, reset release and internal reset wait
    always_comb begin
        clk_en_nxt = cfg[CFG_PAD_SEL] ? cfg[CFG_MOD_EN] : cfg[CFG_HOST_EN];
        rst_n_nxt = clk_en_nxt && cfg[CFG_PER_REL] && !cfg[CFG_SOFT_RST];
        rst_cnt_nxt = rst_cnt_r;
        ready_nxt = ready_r;
        if (!rst_n_r) begin
            rst_cnt_nxt = '0;
            ready_nxt = 1'b0;
        end else if (!ready_r) begin
            if (rst_cnt_r == RESET_WAIT_LAST) begin
                ready_nxt = 1'b1;
            end else begin
                rst_cnt_nxt = rst_cnt_r + 10'd1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clk_en_r <= 1'b0;
            rst_n_r <= 1'b0;
            ready_r <= 1'b0;
            rst_cnt_r <= '0;
        end else if (ce) begin
            clk_en_r <= clk_en_nxt;
            rst_n_r <= rst_n_nxt;
            ready_r <= ready_nxt;
            rst_cnt_r <= rst_cnt_nxt;
        end
    end

    assign run = rst_n_r && ready_r;

    // system bus master and time-out
    master_state_t state_r;
    master_state_t state_nxt;
    bus_req_t req_r;
    bus_req_t req_nxt;
    logic [12:0] cnt_r;
    logic [12:0] cnt_nxt;
    logic taken_r;
    logic taken_nxt;
    logic done_r;
    logic done_nxt;
    logic fault_r;
    logic fault_nxt;
    logic timeout_disable_bit_r;
    logic to_fire;

    // one access in flight; address passes untranslated to the bus
    always_comb begin
        state_nxt = state_r;
        req_nxt = req_r;
        cnt_nxt = cnt_r;
        taken_nxt = 1'b0;
        done_nxt = 1'b0;
        fault_nxt = 1'b0;
        to_fire = 1'b0;
        if (!run) begin
            state_nxt = ST_IDLE;
            cnt_nxt = '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (core_req_valid) begin
                        req_nxt = core_req;
                        cnt_nxt = '0;
                        taken_nxt = 1'b1;
                        state_nxt = ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    if (bus_done) begin
                        done_nxt = 1'b1;
                        state_nxt = ST_IDLE;
                    end else if (!timeout_disable_bit_r && cnt_r == TIMEOUT_LAST) begin
                        to_fire = 1'b1;
                        fault_nxt = 1'b1;
                        state_nxt = ST_IDLE;
                    end else if (!timeout_disable_bit_r) begin
                        cnt_nxt = cnt_r + 13'd1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            req_r <= '0;
            cnt_r <= '0;
            taken_r <= 1'b0;
            done_r <= 1'b0;
            fault_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            req_r <= req_nxt;
            cnt_r <= cnt_nxt;
            taken_r <= taken_nxt;
            done_r <= done_nxt;
            fault_r <= fault_nxt;
        end
    end

    // registers and fault capture
    logic [31:0] fault_addr_r;
    logic [31:0] fault_addr_nxt;
    logic fault_dir_r;
    logic fault_dir_nxt;
    logic timeout_disable_bit_nxt;
    logic ue_flag_r;
    logic ue_flag_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic irq_r;
    logic irq_nxt;
    logic ue_clear;

    assign ue_clear = reg_wr && reg_addr == ERROR_FLAG_OFS && reg_wdata[ERROR_FLAG_BIT];

    // capture on time-out only; error flag set wins over clear
    always_comb begin
        fault_addr_nxt = fault_addr_r;
        fault_dir_nxt = fault_dir_r;
        timeout_disable_bit_nxt = timeout_disable_bit_r;
        ue_flag_nxt = ue_flag_r;
        rdata_nxt = '0;
        if (!rst_n_r) begin
            fault_addr_nxt = FAULT_ADDR_RST;
            fault_dir_nxt = FAULT_DIR_RST;
            timeout_disable_bit_nxt = TIMEOUT_DIS_RST;
            ue_flag_nxt = 1'b0;
        end else begin
            if (reg_wr && reg_addr == TIMEOUT_CTRL_OFS) begin
                timeout_disable_bit_nxt = reg_wdata[TIMEOUT_DIS_BIT];
            end
            if (ue_clear) begin
                ue_flag_nxt = 1'b0;
            end
            if (to_fire) begin
                fault_addr_nxt = req_r.addr;
                fault_dir_nxt = req_r.write;
                ue_flag_nxt = 1'b1;
            end else if (run && iso_fault) begin
                ue_flag_nxt = 1'b1;
            end
        end
        if (reg_rd) begin
            rdata_nxt = read_mux(reg_addr, fault_addr_r, fault_dir_r, timeout_disable_bit_r, ue_flag_r);
        end
        // std_irq carries no overcurrent or ownership source
        irq_nxt = rst_n_r && (ue_flag_r || (|std_irq));
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fault_addr_r <= FAULT_ADDR_RST;
            fault_dir_r <= FAULT_DIR_RST;
            timeout_disable_bit_r <= TIMEOUT_DIS_RST;
            ue_flag_r <= 1'b0;
            rdata_r <= '0;
            irq_r <= 1'b0;
        end else if (ce) begin
            fault_addr_r <= fault_addr_nxt;
            fault_dir_r <= fault_dir_nxt;
            timeout_disable_bit_r <= timeout_disable_bit_nxt;
            ue_flag_r <= ue_flag_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata = rdata_r;
    assign ctl_clk_en = clk_en_r;
    assign ctl_rst_n = rst_n_r;
    assign ctl_ready = ready_r;
    assign core_req_taken = taken_r;
    assign core_done = done_r;
    assign core_fault = fault_r;
    assign bus_valid = (state_r == ST_BUSY);
    assign bus_req = req_r;
    assign irq = irq_r;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_fault_addr_latch: assert property (ce && to_fire |=> fault_addr_r == $past(req_r.addr))
        else $error("fault address not captured on time-out");
    a_fault_dir_bit: assert property (ce && to_fire |=> fault_dir_r == $past(req_r.write))
        else $error("fault direction wrong after time-out");
    a_timeout_off: assert property (timeout_disable_bit_r |-> !to_fire)
        else $error("time-out fired while disabled");
    a_timeout_fires: assert property (ce && run && state_r == ST_BUSY && !bus_done && !timeout_disable_bit_r
        && cnt_r == TIMEOUT_LAST |=> core_fault && state_r == ST_IDLE)
        else $error("time-out missed at 4096 clocks");
    a_ue_raised: assert property (ce && to_fire |=> ue_flag_r ##1 (irq || !ce || !rst_n_r))
        else $error("time-out did not raise error interrupt");
    a_iso_no_capture: assert property (ce && run && iso_fault && !to_fire
        |=> ue_flag_r && $stable(fault_addr_r) && $stable(fault_dir_r))
        else $error("iso fault touched capture registers");
    a_rev_read: assert property (ce && reg_rd && reg_addr == REVISION_OFS
        |=> reg_rdata == {24'h00_0000, MAJOR_REV, MINOR_REV})
        else $error("revision read wrong");
    a_clk_gate: assert property (ce |=> ctl_clk_en == $past(cfg[CFG_PAD_SEL] ? cfg[CFG_MOD_EN]
        : cfg[CFG_HOST_EN]))
        else $error("clock gate follows wrong source");
    a_rst_hold: assert property (ce && (!cfg[CFG_PER_REL] || cfg[CFG_SOFT_RST]) |=> !ctl_rst_n)
        else $error("controller left reset while held");
    a_reset_wait: assert property (ce && !rst_n_r |=> !ctl_ready)
        else $error("ready while controller in reset");
    a_irq_level: assert property (ce && ue_flag_r && rst_n_r |=> irq)
        else $error("interrupt level dropped with flag set");
    a_cnt_restart: assert property (ce && taken_nxt |=> cnt_r == 13'd0 && bus_valid)
        else $error("counter not restarted for new access");
    a_rst_release: assert property (ce && cfg[CFG_PER_REL] && !cfg[CFG_SOFT_RST]
        && (cfg[CFG_PAD_SEL] ? cfg[CFG_MOD_EN] : cfg[CFG_HOST_EN]) |=> ctl_rst_n)
        else $error("controller held in reset while released");
    a_state_wiped: assert property (ce && !rst_n_r |=> fault_addr_r == FAULT_ADDR_RST
        && timeout_disable_bit_r == TIMEOUT_DIS_RST && !ue_flag_r && state_r == ST_IDLE)
        else $error("support state kept through controller reset");
    a_addr_physical: assert property (ce && taken_nxt |=> bus_req == $past(core_req))
        else $error("bus address differs from core address");
    a_std_irq_pass: assert property (ce && rst_n_r && (|std_irq) |=> irq)
        else $error("standard interrupt not passed to line");

endmodule : host_support

// ===== bench/mem_bus_responder.sv
// memory bus slave model answering the support block's bus master port.
// assumes one bus_done pulse per access; delay 0 means it never answers.
`timescale 1ns/1ps
module mem_bus_responder (
    input wire logic clk,
    input wire logic rstn,
    input wire logic bus_valid,
    input wire host_support_pkg::bus_req_t bus_req,
    input wire integer delay,
    output logic bus_done
);
    import host_support_pkg::*;

    int cnt;
    logic served;

    // count cycles of the access in flight, pulse done once after delay
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 0;
            served <= 1'b0;
            bus_done <= 1'b0;
        end else begin
            bus_done <= 1'b0;
            if (!bus_valid) begin
                cnt <= 0;
                served <= 1'b0;
            end else if (!served && delay != 0) begin
                cnt <= cnt + 1;
                if (cnt + 1 >= delay) begin
                    bus_done <= 1'b1;
                    served <= 1'b1; // one pulse per access
                end
            end
        end
    end
endmodule : mem_bus_responder

// ===== bench/host_support_tb.sv
// self-checking bench for the host support block with a memory bus model.
// assumes the register map and timing constants of host_support_pkg.
`timescale 1ns/1ps
module host_support_tb;
    import host_support_pkg::*;

    typedef struct packed {
        logic [4:0] pins; // soft, release, module, host, pad select
        logic clk_en;
        logic rst_n;
    } gate_row_t;

    logic clk, rstn, ce, reg_wr, reg_rd, bus_done, iso_fault, irq;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic pad_sel, host_en, mod_en, per_rel, soft_rst;
    logic ctl_clk_en, ctl_rst_n, ctl_ready;
    logic core_req_valid, core_req_taken, core_done, core_fault, bus_valid;
    bus_req_t core_req, bus_req;
    logic [STD_IRQ_W-1:0] std_irq;
    int resp_delay, fails, check_count, n;
    gate_row_t rows [7];

    host_support DUT (.clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_enable_select(pad_sel),
        .host_enable_bit(host_en), .module_config_host_enable(mod_en), .peripheral_release_bit(per_rel),
        .soft_reset_bit(soft_rst), .ctl_clk_en(ctl_clk_en), .ctl_rst_n(ctl_rst_n), .ctl_ready(ctl_ready),
        .core_req_valid(core_req_valid), .core_req(core_req), .core_req_taken(core_req_taken),
        .core_done(core_done), .core_fault(core_fault), .bus_valid(bus_valid), .bus_req(bus_req),
        .bus_done(bus_done), .std_irq(std_irq), .iso_fault(iso_fault), .irq(irq));

    mem_bus_responder partner (.clk(clk), .rstn(rstn), .bus_valid(bus_valid), .bus_req(bus_req),
        .delay(resp_delay), .bus_done(bus_done));

    // clock generator
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // compare and count
    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // read data is looked at only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input string nm);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        check(nm, reg_rdata, exp);
    endtask : reg_read

    task automatic wait_cycles(input int c);
        repeat (c) @(posedge clk);
    endtask : wait_cycles

    // one core access; counts edges from acceptance to done or fault
    task automatic access(input logic [31:0] a, input logic w, input int dly, input logic exp_fault,
                          input int exp_n);
        int k;
        k = 0;
        @(posedge clk);
        core_req_valid <= 1'b1;
        core_req <= '{addr: a, write: w};
        resp_delay <= dly;
        while (core_req_taken !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
        end
        check("bus_req", bus_req, {a, w});
        check("bus_valid", bus_valid, 1'b1);
        core_req_valid <= 1'b0;
        k = 0;
        while (core_done !== 1'b1 && core_fault !== 1'b1 && k < 6000) begin
            @(posedge clk);
            k++;
        end
        check("core_fault", core_fault, exp_fault);
        check("core_done", core_done, !exp_fault);
        check("bus_idle", bus_valid, 1'b0);
        if (exp_n > 0) check("access_cycles", k, exp_n);
    endtask : access

    // watchdog
    initial begin
        wait_cycles(80000);
        fails++;
        print_verdict();
    end

    initial begin
        {rstn, ce, reg_wr, reg_rd, iso_fault, core_req_valid} = 6'b010000;
        {reg_addr, reg_wdata, core_req, std_irq, resp_delay} = '0;
        {soft_rst, per_rel, mod_en, host_en, pad_sel} = 5'b01010;
        rows = '{'{5'b01010, 1'b1, 1'b1}, '{5'b01100, 1'b0, 1'b0}, '{5'b01101, 1'b1, 1'b1},
                 '{5'b01011, 1'b0, 1'b0}, '{5'b00010, 1'b1, 1'b0}, '{5'b11010, 1'b1, 1'b0},
                 '{5'b01010, 1'b1, 1'b1}};
        wait_cycles(5);
        rstn <= 1'b1;
        n = 0;
        while (ctl_rst_n !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (ctl_ready !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        check("ready_delay", n, RESET_WAIT_CYCLES);
        // software waits for ready and polls reset defaults first
        reg_read(REVISION_OFS, {24'h00_0000, MAJOR_REV, MINOR_REV}, "revision");
        reg_read(FAULT_ADDR_OFS, 32'h0000_0000, "fault_addr_rst");
        reg_read(FAULT_DIR_OFS, 32'h0000_0000, "fault_dir_rst");
        reg_read(TIMEOUT_CTRL_OFS, 32'h0000_0000, "timeout_ctrl_rst");
        reg_read(ERROR_FLAG_OFS, 32'h0000_0000, "error_flag_rst");
        reg_read(8'h14, 32'h0000_0000, "unmapped");
        $display("test reset_values done");

        access(32'h8000_1234, 1'b1, 3, 1'b0, 4);
        check("irq_quiet", irq, 1'b0);
        reg_read(FAULT_ADDR_OFS, 32'h0000_0000, "addr_after_ok");
        $display("test normal_access done");

        access(32'hA5A5_0F0C, 1'b1, 0, 1'b1, TIMEOUT_CYCLES);
        wait_cycles(2);
        check("irq_timeout", irq, 1'b1);
        reg_read(FAULT_ADDR_OFS, 32'hA5A5_0F0C, "fault_addr_wr");
        reg_read(FAULT_DIR_OFS, 32'h0000_0001, "fault_dir_wr");
        reg_write(ERROR_FLAG_OFS, 32'h0000_0001);
        access(32'h1234_5678, 1'b0, 0, 1'b1, TIMEOUT_CYCLES);
        reg_read(FAULT_ADDR_OFS, 32'h1234_5678, "fault_addr_rd");
        reg_read(FAULT_DIR_OFS, 32'h0000_0000, "fault_dir_rd");
        reg_write(ERROR_FLAG_OFS, 32'h0000_0001);
        wait_cycles(3);
        check("irq_cleared", irq, 1'b0);
        $display("test timeouts done");

        // read-modify-write of the control register
        reg_read(TIMEOUT_CTRL_OFS, 32'h0000_0000, "ctrl_before");
        reg_write(TIMEOUT_CTRL_OFS, 32'h0000_0001);
        reg_read(TIMEOUT_CTRL_OFS, 32'h0000_0001, "ctrl_after");
        access(32'h0000_4000, 1'b1, 4300, 1'b0, 4301);
        reg_read(FAULT_ADDR_OFS, 32'h1234_5678, "addr_kept_dis");
        $display("test timeout_disable done");

        @(posedge clk);
        iso_fault <= 1'b1;
        @(posedge clk);
        iso_fault <= 1'b0;
        wait_cycles(6);
        check("irq_iso", irq, 1'b1);
        reg_read(FAULT_ADDR_OFS, 32'h1234_5678, "addr_kept_iso");
        reg_read(FAULT_DIR_OFS, 32'h0000_0000, "dir_kept_iso");
        reg_write(ERROR_FLAG_OFS, 32'h0000_0001);
        for (int i = 0; i < STD_IRQ_W; i++) begin
            @(posedge clk);
            std_irq <= STD_IRQ_W'(1) << i;
            wait_cycles(4);
            check("irq_std_on", irq, 1'b1);
            std_irq <= '0;
            wait_cycles(4);
            check("irq_std_off", irq, 1'b0);
        end
        // clock enable low freezes the interrupt line
        @(posedge clk);
        ce <= 1'b0;
        std_irq <= STD_IRQ_W'(1);
        wait_cycles(4);
        check("irq_frozen", irq, 1'b0);
        ce <= 1'b1;
        wait_cycles(4);
        check("irq_thawed", irq, 1'b1);
        std_irq <= '0;
        $display("test interrupts done");

        // gating table, last row restores normal operation
        for (int r = 0; r < 7; r++) begin
            @(posedge clk);
            {soft_rst, per_rel, mod_en, host_en, pad_sel} <= rows[r].pins;
            wait_cycles(12);
            check("ctl_clk_en", ctl_clk_en, rows[r].clk_en);
            check("ctl_rst_n", ctl_rst_n, rows[r].rst_n);
        end
        n = 0;
        while (ctl_ready !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        check("ready_again", ctl_ready, 1'b1);
        reg_read(FAULT_ADDR_OFS, 32'h0000_0000, "addr_wiped");
        reg_read(TIMEOUT_CTRL_OFS, 32'h0000_0000, "ctrl_wiped");
        $display("test gating done");
        print_verdict();
    end
endmodule : host_support_tb
